// >>> i2c_port_pkg.sv
// Summary of operation
// R01 - Device is target only, up to 1000 kHz
// R02 - Fixed 7-bit target address, not configurable
// R03 - Data changes only while clock is low
// R04 - Start/stop: data falls/rises while clock high
// R05 - Repeated start acts as start, bus busy
// R06 - Nine clocks per byte, MSB first
// R07 - Low data on ninth clock means acknowledge
// R08 - Unlimited bytes between start and stop
// R09 - Master sends address plus direction bit first
// R10 - Write: register address, then acknowledged data bytes
// R11 - Device drives every acknowledge during writes
// R12 - Write data auto-increments register address
// R13 - Read: write address, restart, address with read
// R14 - Read returns consecutive registers, address auto-increments
// R15 - Master alone makes clock, start and stop
// R16 - Address mismatch: no acknowledge, stay released
// R17 - Master NACKs final read byte before stop
package i2c_port_pkg;
	localparam logic [6:0] TARGET_ADDR = 7'h5A;
	localparam logic [3:0] BYTE_BITS = 4'h8;
	localparam logic [7:0] PTR_RESET = 8'h00;
	localparam int CLK_PERIOD_NS = 4;
	localparam int SCL_PERIOD_NS = 1000; // fastest documented rate, 1000 kHz
	// quarter of the serial clock period, rounded up so the rate never exceeds the limit
	localparam int QUARTER_CYCLES = (SCL_PERIOD_NS / CLK_PERIOD_NS + 3) / 4;

	typedef enum logic [9:0] {
		TGT_IDLE = 10'h001,
		TGT_ADDR = 10'h002,
		TGT_ADDR_ACK = 10'h004,
		TGT_REG = 10'h008,
		TGT_REG_ACK = 10'h010,
		TGT_WDATA = 10'h020,
		TGT_WDATA_ACK = 10'h040,
		TGT_RDATA = 10'h080,
		TGT_RDATA_ACK = 10'h100,
		TGT_IGNORE = 10'h200
	} tgt_state_t;

	typedef enum logic [3:0] {
		CTL_IDLE = 4'h1,
		CTL_START = 4'h2,
		CTL_BIT = 4'h4,
		CTL_STOP = 4'h8
	} ctl_state_t;

	typedef enum logic [4:0] {
		STG_ADDR_W = 5'h01,
		STG_REG = 5'h02,
		STG_WDATA = 5'h04,
		STG_ADDR_R = 5'h08,
		STG_RDATA = 5'h10
	} ctl_stage_t;
endpackage

// >>> i2c_link_if.sv
`timescale 1ns/10ps
interface i2c_link_if;
	logic host_scl_out;
	logic host_scl_oe_n;
	logic host_sda_out;
	logic host_sda_oe_n;
	logic tgt_sda_out;
	logic tgt_sda_oe_n;
	logic scl_line;
	logic sda_line;

	// open-drain wired-and with pull-ups; a released driver reads as high
	assign scl_line = host_scl_oe_n | host_scl_out;
	assign sda_line = (host_sda_oe_n | host_sda_out) & (tgt_sda_oe_n | tgt_sda_out);

	modport target (input scl_line, input sda_line, output tgt_sda_out, output tgt_sda_oe_n);
	modport controller (input scl_line, input sda_line, output host_scl_out, output host_scl_oe_n,
		output host_sda_out, output host_sda_oe_n);
endinterface

// >>> i2c_target_port.sv
`timescale 1ns/10ps
module i2c_target_port (
	// clock and reset
	input wire logic core_clk_in,
	input wire logic rst_n_in,
	// serial bus
	i2c_link_if.target link,
	// register file side
	output logic [7:0] reg_addr_out,
	output logic [7:0] reg_wdata_out,
	output logic reg_wr_out,
	output logic reg_rd_out,
	input wire logic [7:0] reg_rdata_in,
	// status
	output logic busy_out
);
	logic scl_meta_reg;
	logic scl_sync_reg;
	logic scl_prev_reg;
	logic sda_meta_reg;
	logic sda_sync_reg;
	logic sda_prev_reg;
	logic start_det;
	logic stop_det;
	logic scl_rise;
	logic scl_fall;
	i2c_port_pkg::tgt_state_t state_reg;
	i2c_port_pkg::tgt_state_t state_next;
	logic [3:0] cnt_reg;
	logic [3:0] cnt_next;
	logic [7:0] shift_reg;
	logic [7:0] shift_next;
	logic [7:0] ptr_reg;
	logic [7:0] ptr_next;
	logic drive_reg;
	logic drive_next;
	logic rw_reg;
	logic rw_next;
	logic mack_reg;
	logic mack_next;
	logic wr_reg;
	logic wr_next;
	logic rd_reg;
	logic rd_next;
	logic busy_reg;
	logic busy_next;

	// two-stage synchronisers; the prev stage feeds edge detection only
	always_ff @(posedge core_clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			scl_meta_reg <= 1'b1;
			scl_sync_reg <= 1'b1;
			scl_prev_reg <= 1'b1;
			sda_meta_reg <= 1'b1;
			sda_sync_reg <= 1'b1;
			sda_prev_reg <= 1'b1;
		end
		else
		begin
			scl_meta_reg <= link.scl_line;
			scl_sync_reg <= scl_meta_reg;
			scl_prev_reg <= scl_sync_reg;
			sda_meta_reg <= link.sda_line;
			sda_sync_reg <= sda_meta_reg;
			sda_prev_reg <= sda_sync_reg;
		end
	end

	// bus conditions, seen on the synchronised copies
	assign start_det = scl_sync_reg & scl_prev_reg & sda_prev_reg & ~sda_sync_reg; // R04
	assign stop_det = scl_sync_reg & scl_prev_reg & ~sda_prev_reg & sda_sync_reg; // R04
	assign scl_rise = scl_sync_reg & ~scl_prev_reg;
	assign scl_fall = ~scl_sync_reg & scl_prev_reg;

	// protocol engine: data is sampled on clock rise and driven only after clock fall
	always_comb
	begin
		state_next = state_reg;
		cnt_next = cnt_reg;
		shift_next = shift_reg;
		ptr_next = ptr_reg;
		drive_next = drive_reg;
		rw_next = rw_reg;
		mack_next = mack_reg;
		wr_next = 1'b0;
		rd_next = 1'b0;
		busy_next = busy_reg;
		if (start_det)
		begin
			// a repeated start restarts framing and keeps the bus busy
			state_next = i2c_port_pkg::TGT_ADDR; // R05
			cnt_next = 4'h0;
			drive_next = 1'b0;
			busy_next = 1'b1; // R05
		end
		else if (stop_det)
		begin
			state_next = i2c_port_pkg::TGT_IDLE;
			drive_next = 1'b0;
			busy_next = 1'b0;
		end
		else if (scl_rise)
		begin
			case (state_reg)
				i2c_port_pkg::TGT_ADDR, i2c_port_pkg::TGT_REG, i2c_port_pkg::TGT_WDATA:
				begin
					if (cnt_reg < i2c_port_pkg::BYTE_BITS)
					begin
						shift_next = {shift_reg[6:0], sda_sync_reg}; // R06
						cnt_next = cnt_reg + 4'h1;
					end
				end
				i2c_port_pkg::TGT_RDATA:
				begin
					cnt_next = cnt_reg + 4'h1;
				end
				i2c_port_pkg::TGT_RDATA_ACK:
				begin
					// pointer moves at the acknowledge clock so the next byte is ready by its fall
					mack_next = ~sda_sync_reg; // R07
					ptr_next = ptr_reg + 8'h01; // R14
				end
				default:
				begin
					cnt_next = cnt_reg;
				end
			endcase
		end
		else if (scl_fall)
		begin
			case (state_reg)
				i2c_port_pkg::TGT_ADDR:
				begin
					if (cnt_reg == i2c_port_pkg::BYTE_BITS)
					begin
						if (shift_reg[7:1] == i2c_port_pkg::TARGET_ADDR) // R02
						begin
							drive_next = 1'b1; // R07
							rw_next = shift_reg[0];
							state_next = i2c_port_pkg::TGT_ADDR_ACK;
						end
						else
						begin
							state_next = i2c_port_pkg::TGT_IGNORE; // R16
						end
					end
				end
				i2c_port_pkg::TGT_REG:
				begin
					if (cnt_reg == i2c_port_pkg::BYTE_BITS)
					begin
						ptr_next = shift_reg; // R10
						drive_next = 1'b1; // R11
						state_next = i2c_port_pkg::TGT_REG_ACK;
					end
				end
				i2c_port_pkg::TGT_WDATA:
				begin
					if (cnt_reg == i2c_port_pkg::BYTE_BITS)
					begin
						wr_next = 1'b1;
						drive_next = 1'b1; // R11
						state_next = i2c_port_pkg::TGT_WDATA_ACK;
					end
				end
				i2c_port_pkg::TGT_ADDR_ACK, i2c_port_pkg::TGT_RDATA_ACK:
				begin
					cnt_next = 4'h0;
					drive_next = 1'b0;
					if (state_reg == i2c_port_pkg::TGT_ADDR_ACK && !rw_reg)
					begin
						state_next = i2c_port_pkg::TGT_REG;
					end
					else if (state_reg == i2c_port_pkg::TGT_ADDR_ACK || mack_reg)
					begin
						// load the byte at the pointer and drive its MSB during clock low
						shift_next = reg_rdata_in; // R14
						drive_next = ~reg_rdata_in[7]; // R03
						rd_next = 1'b1;
						state_next = i2c_port_pkg::TGT_RDATA;
					end
					else
					begin
						state_next = i2c_port_pkg::TGT_IGNORE;
					end
				end
				i2c_port_pkg::TGT_REG_ACK, i2c_port_pkg::TGT_WDATA_ACK:
				begin
					cnt_next = 4'h0;
					drive_next = 1'b0;
					if (state_reg == i2c_port_pkg::TGT_WDATA_ACK)
					begin
						ptr_next = ptr_reg + 8'h01; // R12
					end
					state_next = i2c_port_pkg::TGT_WDATA; // R08
				end
				i2c_port_pkg::TGT_RDATA:
				begin
					if (cnt_reg == i2c_port_pkg::BYTE_BITS)
					begin
						// release so the master can answer in the ninth clock
						drive_next = 1'b0;
						cnt_next = 4'h0;
						state_next = i2c_port_pkg::TGT_RDATA_ACK;
					end
					else
					begin
						shift_next = {shift_reg[6:0], 1'b0}; // R06
						drive_next = ~shift_reg[6]; // R03
					end
				end
				default:
				begin
					drive_next = 1'b0;
				end
			endcase
		end
	end

	// protocol state registers
	always_ff @(posedge core_clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			state_reg <= i2c_port_pkg::TGT_IDLE;
			cnt_reg <= 4'h0;
			shift_reg <= 8'h00;
			ptr_reg <= i2c_port_pkg::PTR_RESET;
			drive_reg <= 1'b0;
			rw_reg <= 1'b0;
			mack_reg <= 1'b0;
			wr_reg <= 1'b0;
			rd_reg <= 1'b0;
			busy_reg <= 1'b0;
		end
		else
		begin
			state_reg <= state_next;
			cnt_reg <= cnt_next;
			shift_reg <= shift_next;
			ptr_reg <= ptr_next;
			drive_reg <= drive_next;
			rw_reg <= rw_next;
			mack_reg <= mack_next;
			wr_reg <= wr_next;
			rd_reg <= rd_next;
			busy_reg <= busy_next;
		end
	end

	// target only ever pulls data low; the clock pin is never driven
	assign link.tgt_sda_out = 1'b0; // R01
	assign link.tgt_sda_oe_n = ~drive_reg;
	assign reg_addr_out = ptr_reg;
	assign reg_wdata_out = shift_reg;
	assign reg_wr_out = wr_reg;
	assign reg_rd_out = rd_reg;
	assign busy_out = busy_reg;
endmodule // i2c_target_port

// >>> i2c_controller_port.sv
`timescale 1ns/10ps
module i2c_controller_port #(
	parameter int QUARTER = i2c_port_pkg::QUARTER_CYCLES
) (
	// clock and reset
	input wire logic core_clk_in,
	input wire logic rst_n_in,
	// serial bus
	i2c_link_if.controller link,
	// command
	input wire logic cmd_valid_in,
	output logic cmd_ready_out,
	input wire logic cmd_read_in,
	input wire logic [7:0] cmd_reg_in,
	input wire logic [7:0] cmd_len_in,
	// data
	input wire logic [7:0] wr_data_in,
	output logic wr_take_out,
	output logic [7:0] rd_data_out,
	output logic rd_valid_out,
	// completion
	output logic done_out,
	output logic nack_out
);
	logic sda_meta_reg;
	logic sda_sync_reg;
	logic tick;
	logic [7:0] div_reg;
	i2c_port_pkg::ctl_state_t state_reg, state_next;
	i2c_port_pkg::ctl_stage_t stage_reg, stage_next;
	logic [1:0] q_reg, q_next;
	logic [3:0] bitn_reg, bitn_next;
	logic [8:0] tx_reg, tx_next;
	logic [8:0] rx_reg, rx_next;
	logic [7:0] len_reg, len_next;
	logic [7:0] regaddr_reg, regaddr_next;
	logic read_reg, read_next;
	logic scl_low_reg, scl_low_next;
	logic sda_low_reg, sda_low_next;
	logic take_reg, take_next;
	logic [7:0] rdata_reg, rdata_next;
	logic rvalid_reg, rvalid_next;
	logic done_reg, done_next;
	logic nack_reg, nack_next;
	logic [8:0] rxv;

	// data readback synchroniser and quarter-period divider
	always_ff @(posedge core_clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			sda_meta_reg <= 1'b1;
			sda_sync_reg <= 1'b1;
			div_reg <= 8'h00;
		end
		else
		begin
			sda_meta_reg <= link.sda_line;
			sda_sync_reg <= sda_meta_reg;
			div_reg <= tick ? 8'h00 : div_reg + 8'h01;
		end
	end
	assign tick = (div_reg == 8'(QUARTER - 1)); // R01
	assign rxv = {rx_reg[7:0], sda_sync_reg};

	// sequencer: clock is made here from the core clock by the divider
	always_comb
	begin
		state_next = state_reg;
		stage_next = stage_reg;
		q_next = q_reg;
		bitn_next = bitn_reg;
		tx_next = tx_reg;
		rx_next = rx_reg;
		len_next = len_reg;
		regaddr_next = regaddr_reg;
		read_next = read_reg;
		scl_low_next = scl_low_reg;
		sda_low_next = sda_low_reg;
		take_next = 1'b0;
		rdata_next = rdata_reg;
		rvalid_next = 1'b0;
		done_next = 1'b0;
		nack_next = nack_reg;
		if (state_reg == i2c_port_pkg::CTL_IDLE)
		begin
			if (cmd_valid_in)
			begin
				read_next = cmd_read_in;
				regaddr_next = cmd_reg_in;
				len_next = cmd_len_in;
				nack_next = 1'b0;
				stage_next = i2c_port_pkg::STG_ADDR_W;
				tx_next = {i2c_port_pkg::TARGET_ADDR, 1'b0, 1'b1}; // R09
				q_next = 2'h0;
				state_next = i2c_port_pkg::CTL_START;
			end
		end
		else if (tick)
		begin
			q_next = q_reg + 2'h1;
			case (state_reg)
				i2c_port_pkg::CTL_START:
				begin
					// start and repeated start share one sequence
					case (q_reg)
						2'h0: sda_low_next = 1'b0;
						2'h1: scl_low_next = 1'b0;
						2'h2: sda_low_next = 1'b1; // R15
						default:
						begin
							scl_low_next = 1'b1;
							bitn_next = 4'h0;
							state_next = i2c_port_pkg::CTL_BIT;
						end
					endcase
				end
				i2c_port_pkg::CTL_BIT:
				begin
					case (q_reg)
						2'h0: scl_low_next = 1'b1;
						2'h1: sda_low_next = ~tx_reg[8]; // R03
						2'h2: scl_low_next = 1'b0;
						default:
						begin
							scl_low_next = 1'b1;
							rx_next = rxv;
							tx_next = {tx_reg[7:0], 1'b1}; // R06
							bitn_next = bitn_reg + 4'h1;
							if (bitn_reg == i2c_port_pkg::BYTE_BITS)
							begin
								bitn_next = 4'h0;
								state_next = i2c_port_pkg::CTL_STOP;
								if (stage_reg == i2c_port_pkg::STG_RDATA)
								begin
									rdata_next = rxv[8:1];
									rvalid_next = 1'b1;
									len_next = len_reg - 8'h01;
									if (len_reg > 8'h01)
									begin
										tx_next = {8'hFF, len_reg == 8'h02}; // R17
										state_next = i2c_port_pkg::CTL_BIT;
									end
								end
								else if (rxv[0])
								begin
									nack_next = 1'b1; // R07
								end
								else if (stage_reg == i2c_port_pkg::STG_ADDR_W)
								begin
									stage_next = i2c_port_pkg::STG_REG;
									tx_next = {regaddr_reg, 1'b1}; // R10
									state_next = i2c_port_pkg::CTL_BIT;
								end
								else if (stage_reg == i2c_port_pkg::STG_ADDR_R)
								begin
									stage_next = i2c_port_pkg::STG_RDATA;
									tx_next = {8'hFF, len_reg == 8'h01}; // R17
									state_next = i2c_port_pkg::CTL_BIT;
								end
								else if (stage_reg == i2c_port_pkg::STG_REG && read_reg)
								begin
									stage_next = i2c_port_pkg::STG_ADDR_R;
									tx_next = {i2c_port_pkg::TARGET_ADDR, 1'b1, 1'b1}; // R13
									state_next = i2c_port_pkg::CTL_START;
								end
								else
								begin
									if (stage_reg == i2c_port_pkg::STG_WDATA)
									begin
										len_next = len_reg - 8'h01;
									end
									if ((stage_reg == i2c_port_pkg::STG_REG && len_reg != 8'h00) ||
										(stage_reg == i2c_port_pkg::STG_WDATA && len_reg > 8'h01))
									begin
										stage_next = i2c_port_pkg::STG_WDATA;
										tx_next = {wr_data_in, 1'b1}; // R10
										take_next = 1'b1;
										state_next = i2c_port_pkg::CTL_BIT;
									end
								end
							end
						end
					endcase
				end
				i2c_port_pkg::CTL_STOP:
				begin
					case (q_reg)
						2'h0: sda_low_next = 1'b1;
						2'h1: scl_low_next = 1'b0;
						2'h2: sda_low_next = 1'b0; // R15
						default:
						begin
							done_next = 1'b1;
							state_next = i2c_port_pkg::CTL_IDLE;
						end
					endcase
				end
				default:
				begin
					state_next = i2c_port_pkg::CTL_IDLE;
				end
			endcase
		end
	end

	// sequencer registers
	always_ff @(posedge core_clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			state_reg <= i2c_port_pkg::CTL_IDLE;
			stage_reg <= i2c_port_pkg::STG_ADDR_W;
			q_reg <= 2'h0;
			bitn_reg <= 4'h0;
			tx_reg <= 9'h1FF;
			rx_reg <= 9'h000;
			len_reg <= 8'h00;
			regaddr_reg <= 8'h00;
			read_reg <= 1'b0;
			scl_low_reg <= 1'b0;
			sda_low_reg <= 1'b0;
			take_reg <= 1'b0;
			rdata_reg <= 8'h00;
			rvalid_reg <= 1'b0;
			done_reg <= 1'b0;
			nack_reg <= 1'b0;
		end
		else
		begin
			state_reg <= state_next;
			stage_reg <= stage_next;
			q_reg <= q_next;
			bitn_reg <= bitn_next;
			tx_reg <= tx_next;
			rx_reg <= rx_next;
			len_reg <= len_next;
			regaddr_reg <= regaddr_next;
			read_reg <= read_next;
			scl_low_reg <= scl_low_next;
			sda_low_reg <= sda_low_next;
			take_reg <= take_next;
			rdata_reg <= rdata_next;
			rvalid_reg <= rvalid_next;
			done_reg <= done_next;
			nack_reg <= nack_next;
		end
	end

	assign link.host_scl_out = 1'b0;
	assign link.host_scl_oe_n = ~scl_low_reg;
	assign link.host_sda_out = 1'b0;
	assign link.host_sda_oe_n = ~sda_low_reg;
	assign cmd_ready_out = (state_reg == i2c_port_pkg::CTL_IDLE);
	assign wr_take_out = take_reg;
	assign rd_data_out = rdata_reg;
	assign rd_valid_out = rvalid_reg;
	assign done_out = done_reg;
	assign nack_out = nack_reg;
endmodule // i2c_controller_port

// >>> i2c_slave_register_port_chk.sv
`timescale 1ns/10ps
module i2c_slave_register_port_chk (
	// clock and reset
	input wire logic core_clk_in,
	input wire logic rst_n_in,
	// bus drivers and levels
	input wire logic host_sda_out,
	input wire logic host_sda_oe_n,
	input wire logic tgt_sda_oe_n,
	input wire logic scl_line,
	input wire logic sda_line
);
	logic scl_reg, scl_next, sda_reg, sda_next, host_reg, host_next, rd_reg, rd_next;
	logic [3:0] slot_reg, slot_next;
	logic [2:0] byte_reg, byte_next;
	wire host_lvl = host_sda_oe_n | host_sda_out;
	wire scl_rise = scl_line && !scl_reg;
	wire start_seen = scl_line && scl_reg && sda_reg && !sda_line;

	// bit slot and byte count since the last start; the byte count saturates, only byte 0 matters
	always_comb
	begin
		scl_next = scl_line;
		sda_next = sda_line;
		host_next = host_lvl;
		slot_next = slot_reg;
		byte_next = byte_reg;
		rd_next = rd_reg;
		if (start_seen)
		begin
			slot_next = 4'h0;
			byte_next = 3'h0;
		end
		else if (scl_rise)
		begin
			slot_next = (slot_reg == 4'h8) ? 4'h0 : slot_reg + 4'h1;
			if (slot_reg == 4'h8 && byte_reg != 3'h7)
				byte_next = byte_reg + 3'h1;
			if (slot_reg == 4'h7 && byte_reg == 3'h0)
				rd_next = sda_line;
		end
	end

	// byte count starts saturated so no address-byte check applies before the first start
	always_ff @(posedge core_clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			scl_reg <= 1'b1;
			sda_reg <= 1'b1;
			host_reg <= 1'b1;
			rd_reg <= 1'b0;
			slot_reg <= 4'h0;
			byte_reg <= 3'h7;
		end
		else
		begin
			scl_reg <= scl_next;
			sda_reg <= sda_next;
			host_reg <= host_next;
			rd_reg <= rd_next;
			slot_reg <= slot_next;
			byte_reg <= byte_next;
		end
	end

	default clocking cb @(posedge core_clk_in);
	endclocking
	default disable iff (!rst_n_in);

	// slot 0 is skipped in data bytes: a stop or restart also begins with a clock rise there
	sequence addr_ack_rise;
		scl_rise && slot_reg == 4'h8 && byte_reg == 3'h0;
	endsequence
	sequence data_bit_rise;
		scl_rise && slot_reg != 4'h0 && slot_reg < 4'h8 && byte_reg != 3'h0;
	endsequence
	sequence data_ack_rise;
		scl_rise && slot_reg == 4'h8 && byte_reg != 3'h0;
	endsequence

	addr_ack_a: assert property (addr_ack_rise |-> (!tgt_sda_oe_n && !sda_line) [*4])
		else $error("address byte not acknowledged");
	addr_idle_a: assert property (scl_rise && slot_reg < 4'h8 && byte_reg == 3'h0 |-> tgt_sda_oe_n)
		else $error("target drives data during address byte");
	wr_ack_a: assert property (data_ack_rise ##0 !rd_reg |-> (!tgt_sda_oe_n) [*2])
		else $error("write byte not acknowledged by target");
	wr_release_a: assert property (data_bit_rise ##0 !rd_reg |-> tgt_sda_oe_n)
		else $error("target drives data during write byte");
	rd_host_a: assert property (data_bit_rise ##0 rd_reg |-> host_sda_oe_n)
		else $error("controller drives data during read byte");
	rd_ack_a: assert property (data_ack_rise ##0 rd_reg |-> tgt_sda_oe_n)
		else $error("target drives controller acknowledge slot");
	high_hold_a: assert property (scl_line && scl_reg |-> $stable(tgt_sda_oe_n))
		else $error("target data changed while clock high");
	host_edge_a: assert property (scl_line && scl_reg && sda_line != sda_reg |-> host_lvl != host_reg)
		else $error("start or stop edge not made by controller");
	scl_high_a: assert property ($rose(scl_line) |-> scl_line [*4])
		else $error("serial clock high phase too short");
endmodule // i2c_slave_register_port_chk

// >>> i2c_slave_register_port_bench.sv
`timescale 1ns/10ps
module i2c_slave_register_port_bench;
	logic core_clk_in = 1'b0;
	logic rst_n_in = 1'b0;
	logic cmd_valid = 1'b0;
	logic cmd_read = 1'b0;
	logic [7:0] cmd_reg = 8'h00;
	logic [7:0] cmd_len = 8'h00;
	logic cmd_ready, wr_take, rd_valid, done, nack, busy, reg_wr, reg_rd, reg_wr2, rd;
	logic [7:0] wr_data, rd_data, reg_addr, reg_wdata, r, n;
	logic [7:0] regs [256];
	logic [7:0] exp_regs [256];
	logic [7:0] wbuf [4];
	logic [7:0] rbuf [$];
	logic [40:0] rows [6];
	int widx, n_fail, samples_checked, cycles, stray, reads, rd_base;
	i2c_link_if link ();
	i2c_link_if link2 ();

	always #2 core_clk_in = ~core_clk_in;

	i2c_controller_port #(.QUARTER(4)) i2c_controller_port_i (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in),
		.link(link), .cmd_valid_in(cmd_valid), .cmd_ready_out(cmd_ready), .cmd_read_in(cmd_read),
		.cmd_reg_in(cmd_reg), .cmd_len_in(cmd_len), .wr_data_in(wr_data), .wr_take_out(wr_take),
		.rd_data_out(rd_data), .rd_valid_out(rd_valid), .done_out(done), .nack_out(nack));
	i2c_target_port i2c_target_port_i (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .link(link),
		.reg_addr_out(reg_addr), .reg_wdata_out(reg_wdata), .reg_wr_out(reg_wr), .reg_rd_out(reg_rd),
		.reg_rdata_in(regs[reg_addr]), .busy_out(busy));
	// second target faces the bench alone, for traffic the controller never makes
	i2c_target_port i2c_target_port_i2 (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .link(link2),
		.reg_addr_out(), .reg_wdata_out(), .reg_wr_out(reg_wr2), .reg_rd_out(), .reg_rdata_in(8'h00),
		.busy_out());
	i2c_slave_register_port_chk i2c_slave_register_port_chk_i (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in),
		.host_sda_out(link.host_sda_out), .host_sda_oe_n(link.host_sda_oe_n), .tgt_sda_oe_n(link.tgt_sda_oe_n),
		.scl_line(link.scl_line), .sda_line(link.sda_line));

	// register file, write feed, read capture, stray drive watch and run limit
	always @(posedge core_clk_in)
	begin
		if (reg_wr === 1'b1)
			regs[reg_addr] <= reg_wdata;
		if (wr_take === 1'b1)
			widx <= widx + 1;
		if (rd_valid === 1'b1)
			rbuf.push_back(rd_data);
		// reset gates the watch: the flops hold no value before the first edge under reset
		if (rst_n_in === 1'b1 && (link2.tgt_sda_oe_n !== 1'b1 || reg_wr2 !== 1'b0))
			stray <= stray + 1;
		if (reg_rd === 1'b1)
			reads <= reads + 1;
		cycles <= cycles + 1;
		if (cycles == 40000)
		begin
			n_fail++;
			complete_run();
		end
	end
	assign wr_data = wbuf[widx[1:0]];

	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// a second rise of busy inside one command means a restart was taken for a stop
	task automatic run_cmd();
		int t;
		int rises;
		logic prev;
		rises = 0;
		prev = 1'b1;
		@(posedge core_clk_in);
		cmd_valid <= 1'b1;
		cmd_read <= rd;
		cmd_reg <= r;
		cmd_len <= n;
		widx <= 0;
		@(posedge core_clk_in);
		cmd_valid <= 1'b0;
		for (t = 0; t < 4000 && done !== 1'b1; t++)
		begin
			@(posedge core_clk_in);
			if (t == 40)
				check("busy", 8'(busy), 8'h01);
			if (t > 40 && busy === 1'b1 && prev !== 1'b1)
				rises++;
			prev = busy;
		end
		check("done", 8'(done), 8'h01);
		@(posedge core_clk_in);
		check("restart", 8'(rises), 8'h00);
		check("nack", 8'(nack), 8'h00);
		check("idle", 8'(busy), 8'h00);
	endtask

	// one quarter of a bench-made link clock period of 64 ns
	task automatic quarter(input logic scl_rel, input logic sda_rel);
		link2.host_scl_oe_n <= scl_rel;
		link2.host_sda_oe_n <= sda_rel;
		repeat (4) @(posedge core_clk_in);
	endtask

	// each bit: clock falls with data held, data moves while the clock is low, then a high half
	task automatic bang_byte(input logic [8:0] v);
		for (int b = 8; b >= 0; b--)
		begin
			quarter(1'b0, link2.host_sda_oe_n);
			quarter(1'b0, v[b]);
			quarter(1'b1, v[b]);
			quarter(1'b1, v[b]);
		end
	endtask

	initial
	begin
		link2.host_scl_out = 1'b0;
		link2.host_sda_out = 1'b0;
		link2.host_scl_oe_n = 1'b1;
		link2.host_sda_oe_n = 1'b1;
		for (int i = 0; i < 256; i++)
		begin
			regs[i] = 8'(i) ^ 8'hA5;
			exp_regs[i] = 8'(i) ^ 8'hA5;
		end
		// rows: direction, register, length, write bytes; back to back, wrap at the top address
		rows = '{{1'b0, 8'h10, 8'h02, 8'h3C, 8'hC3, 8'h00}, {1'b1, 8'h10, 8'h02, 8'h00, 8'h00, 8'h00},
			{1'b0, 8'hFE, 8'h03, 8'h81, 8'h7E, 8'h55}, {1'b1, 8'hFE, 8'h03, 8'h00, 8'h00, 8'h00},
			{1'b0, 8'h20, 8'h00, 8'hFF, 8'h00, 8'h00}, {1'b1, 8'h1F, 8'h03, 8'h00, 8'h00, 8'h00}};
		repeat (2) @(posedge core_clk_in);
		check("pointer", reg_addr, 8'h00);
		check("ready", 8'(cmd_ready), 8'h01);
		check("release", 8'(link.tgt_sda_oe_n), 8'h01);
		rst_n_in <= 1'b1;
		$display("reset test done");
		for (int i = 0; i < 6; i++)
		begin
			{rd, r, n, wbuf[0], wbuf[1], wbuf[2]} = rows[i];
			rbuf.delete();
			rd_base = reads;
			run_cmd();
			check("bytes", 8'(rbuf.size()), rd ? n : 8'h00);
			check("fetches", 8'(reads - rd_base), rd ? n : 8'h00);
			for (int k = 0; k < n; k++)
			begin
				if (!rd)
					exp_regs[8'(r + k)] = wbuf[k];
				check("data", rd ? rbuf[k] : regs[8'(r + k)], exp_regs[8'(r + k)]);
			end
			$display("row %0d done", i);
		end
		// wrong address then a data byte, both left unacknowledged
		quarter(1'b1, 1'b0);
		bang_byte({7'h5B, 1'b0, 1'b1});
		bang_byte({8'h00, 1'b1});
		// stop: the clock falls before the data line moves, so only the final data rise reads as a condition
		quarter(1'b0, link2.host_sda_oe_n);
		quarter(1'b0, 1'b0);
		quarter(1'b1, 1'b0);
		quarter(1'b1, 1'b1);
		check("stray", 8'(stray), 8'h00);
		$display("address test done");
		// reset cuts a write inside its address byte; nothing may land and both ends must recover
		wbuf[0] <= 8'h99;
		@(posedge core_clk_in);
		cmd_valid <= 1'b1;
		cmd_read <= 1'b0;
		cmd_reg <= 8'h40;
		cmd_len <= 8'h01;
		widx <= 0;
		@(posedge core_clk_in);
		cmd_valid <= 1'b0;
		repeat (100) @(posedge core_clk_in);
		check("cut busy", 8'(busy), 8'h01);
		rst_n_in <= 1'b0;
		repeat (2) @(posedge core_clk_in);
		check("cut idle", 8'(busy), 8'h00);
		check("cut ready", 8'(cmd_ready), 8'h01);
		check("cut release", 8'(link.tgt_sda_oe_n), 8'h01);
		check("cut clock", 8'(link.scl_line), 8'h01);
		check("cut pointer", reg_addr, 8'h00);
		rst_n_in <= 1'b1;
		{rd, r, n} = {1'b1, 8'h40, 8'h01};
		rbuf.delete();
		run_cmd();
		check("cut write", regs[8'h40], exp_regs[8'h40]);
		check("cut read", rbuf[0], exp_regs[8'h40]);
		$display("reset cut test done");
		complete_run();
	end
endmodule // i2c_slave_register_port_bench
